/* File: pptj_line_model.sv */
`default_nettype none
// Passive periphery: it only watches the line, so widths are measured in system clocks.
module pptj_line_model (
   // Clock and reset.
   input  wire logic sys_clk,
   input  wire logic nrst,
   // Output line.
   input  wire logic line,
   // Measured shape.
   output logic [31:0] hi_len,
   output logic [31:0] per_len,
   output logic [31:0] n_rise
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        line_q;
   logic [31:0] hi_q;
   logic [31:0] per_q;
   always_ff @(posedge sys_clk) begin
      line_q <= line;
      if (!nrst) begin
         hi_q    <= 32'h0;
         per_q   <= 32'h0;
         hi_len  <= 32'h0;
         per_len <= 32'h0;
         n_rise  <= 32'h0;
      end else begin
         hi_q  <= line ? hi_q + 32'h1 : 32'h0;
         per_q <= (line && !line_q) ? 32'h1 : per_q + 32'h1;
         if (!line && line_q) hi_len <= hi_q;
         if (line && !line_q) per_len <= per_q;
         if (line && !line_q) n_rise <= n_rise + 32'h1;
      end
   end
endmodule : pptj_line_model
`default_nettype wire

/* File: pptj_pkg.sv */
`default_nettype none
package pptj_pkg;
   // Job codes.
   localparam logic [15:0] JOB_NOP       = 16'h0000;
   localparam logic [15:0] JOB_WR_PER1   = 16'h0001;
   localparam logic [15:0] JOB_WR_DELAY  = 16'h0002;
   localparam logic [15:0] JOB_WR_MINP   = 16'h0004;
   localparam logic [15:0] JOB_WR_CNT1   = 16'h0008;
   localparam logic [15:0] JOB_WR_CNT2   = 16'h0009;
   localparam logic [15:0] JOB_WR_PER2   = 16'h000A;
   localparam logic [15:0] JOB_WR_TBASE  = 16'h000B;
   localparam logic [15:0] JOB_ATTACH    = 16'h000C;
   localparam logic [15:0] JOB_RD_PER1   = 16'h0081;
   localparam logic [15:0] JOB_RD_DELAY  = 16'h0082;
   localparam logic [15:0] JOB_RD_MINP   = 16'h0084;
   localparam logic [15:0] JOB_RD_CNT1   = 16'h0088;
   localparam logic [15:0] JOB_RD_CNT2   = 16'h0089;
   localparam logic [15:0] JOB_RD_PER2   = 16'h008A;
   localparam logic [15:0] JOB_RD_TBASE  = 16'h008B;
   // Status codes.
   localparam logic [15:0] ST_OK         = 16'h0000;
   localparam logic [15:0] ST_PER_SMALL  = 16'h0411;
   localparam logic [15:0] ST_PER_BIG    = 16'h0412;
   localparam logic [15:0] ST_DLY_SMALL  = 16'h0421;
   localparam logic [15:0] ST_DLY_BIG    = 16'h0422;
   localparam logic [15:0] ST_MINP_SMALL = 16'h0431;
   localparam logic [15:0] ST_MINP_BIG   = 16'h0432;
   localparam logic [15:0] ST_CNT_SMALL  = 16'h0441;
   localparam logic [15:0] ST_CNT_BIG    = 16'h0442;
   localparam logic [15:0] ST_TBASE_BAD  = 16'h0451;
   localparam logic [15:0] ST_ATTACH_BAD = 16'h0461;
   localparam logic [15:0] ST_JOB_BAD    = 16'h04FF;
   // Time base codes.
   localparam logic [1:0] TB_100US = 2'h0;
   localparam logic [1:0] TB_1MS   = 2'h1;
   localparam logic [1:0] TB_1US   = 2'h2;
   localparam logic [1:0] TB_10US  = 2'h3;
   // Value limits.
   localparam logic [31:0] PER_MAX_1MS   = 32'h0000_0057;
   localparam logic [31:0] PER_MAX_100US = 32'h0000_0366;
   localparam logic [31:0] PER_MAX_10US  = 32'h0000_21FC;
   localparam logic [31:0] PER_MAX_1US   = 32'h0000_FFFF;
   localparam logic [31:0] PER_MIN_1MS   = 32'h0000_0001;
   localparam logic [31:0] PER_MIN_10US  = 32'h0000_0002;
   localparam logic [31:0] PER_MIN_1US   = 32'h0000_0014;
   localparam logic [31:0] DLY_MAX       = 32'h0000_FFFF;
   localparam logic [31:0] MINP_MIN_1US  = 32'h0000_0005;
   localparam logic [31:0] CNT_MAX       = 32'h007F_FFFF;
   localparam logic [15:0] DUTY_MAX_PERMIL = 16'h03E8;
   localparam logic [15:0] DUTY_MAX_ANALOG = 16'h6C00;
   // Reset values.
   localparam logic [15:0] PER_RESET   = 16'h4E20;
   localparam logic [15:0] MINP_RESET  = 16'h0002;
   localparam logic [1:0]  TBASE_RESET = TB_100US;
   // Prescaler counts for a 20 MHz clock.
   localparam int          CLK_HZ      = 20000000;
   localparam int          TICK_1US_HZ = 1000000;
   localparam logic [15:0] DIV_1US   = 16'(CLK_HZ / TICK_1US_HZ);
   localparam logic [15:0] DIV_10US  = 16'(CLK_HZ / (TICK_1US_HZ / 10));
   localparam logic [15:0] DIV_100US = 16'(CLK_HZ / (TICK_1US_HZ / 100));
   localparam logic [15:0] DIV_1MS   = 16'(CLK_HZ / (TICK_1US_HZ / 1000));

   typedef struct packed {
      logic [15:0] code;
      logic [31:0] value;
   } pptj_job_t;

   typedef struct packed {
      logic        done;
      logic        err;
      logic [15:0] stat;
      logic [31:0] result;
   } pptj_resp_t;
endpackage : pptj_pkg
`default_nettype wire

/* File: pptj_tick.sv */
`default_nettype none
module pptj_tick (
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // Time base select and restart.
   input  wire logic [1:0] tbase,
   input  wire logic       restart,
   // One-cycle tick.
   output logic            tick
);
   logic [15:0] cnt_q;
   logic [15:0] div;

   assign div = (tbase == pptj_pkg::TB_1US)  ? pptj_pkg::DIV_1US :
                (tbase == pptj_pkg::TB_10US) ? pptj_pkg::DIV_10US :
                (tbase == pptj_pkg::TB_1MS)  ? pptj_pkg::DIV_1MS : pptj_pkg::DIV_100US;

   always_ff @(posedge sys_clk) begin
      if (!nrst || restart || cnt_q >= div - 16'h0001) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      tick <= nrst && !restart && (cnt_q >= div - 16'h0001);
   end
endmodule : pptj_tick
`default_nettype wire

/* File: pptj_unit.sv */
`default_nettype none
module pptj_unit (
   // Clock and reset.
   input  wire logic                  sys_clk,
   input  wire logic                  nrst,
   // Configuration and gate.
   input  wire logic                  format_analog,
   input  wire logic                  software_gate,
   input  wire logic [15:0]           duty_value,
   // Job request.
   input  wire logic                  job_req,
   input  wire pptj_pkg::pptj_job_t   job_in,
   // Job answer and status.
   output pptj_pkg::pptj_resp_t       job_resp,
   output logic                       output_active_status,
   output logic                       pulse_out
);
   typedef enum logic [2:0] {S_IDLE, S_DELAY, S_RUN1, S_RUN2} pptj_state_t;

   pptj_state_t state_q, state_d;
   logic        req_q, gate_q;
   logic [15:0] per1_q, per2_q, dly_q, minp_q, duty2_q;
   logic [22:0] cnt1_q, cnt2_q, left_q;
   logic [1:0]  tbase_q;
   logic        chain_q;
   logic [15:0] per_a_q, on_a_q, pos_q, dly_cnt_q;
   pptj_pkg::pptj_resp_t resp_d;

   wire        req_rise  = job_req && !req_q;
   wire        gate_rise = software_gate && !gate_q;
   wire        tick;
   wire [15:0] code = job_in.code;
   wire [31:0] val  = job_in.value;
   wire        neg  = val[31];

   pptj_tick u_tick (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .tbase   (tbase_q),
      .restart (gate_rise),
      .tick    (tick)
   );

   // Period range for the present time base.
   wire [31:0] per_min = (tbase_q == pptj_pkg::TB_1US)  ? pptj_pkg::PER_MIN_1US :
                         (tbase_q == pptj_pkg::TB_10US) ? pptj_pkg::PER_MIN_10US : pptj_pkg::PER_MIN_1MS;
   wire [31:0] per_max = (tbase_q == pptj_pkg::TB_1US)   ? pptj_pkg::PER_MAX_1US :
                         (tbase_q == pptj_pkg::TB_10US)  ? pptj_pkg::PER_MAX_10US :
                         (tbase_q == pptj_pkg::TB_100US) ? pptj_pkg::PER_MAX_100US : pptj_pkg::PER_MAX_1MS;
   wire [31:0] minp_lo = (tbase_q == pptj_pkg::TB_1US) ? pptj_pkg::MINP_MIN_1US : 32'h0000_0000;
   wire [31:0] half_p  = {17'h00000, per1_q[15:1]};

   // Duty scaling: on time = duty * period / full scale.
   wire [15:0] dmax     = format_analog ? pptj_pkg::DUTY_MAX_ANALOG : pptj_pkg::DUTY_MAX_PERMIL;
   wire [15:0] duty_pwm = (duty_value > dmax) ? dmax : duty_value;
   // The next state picks the set, so the first period of the second job already uses its own values.
   wire [15:0] duty_use = (state_d == S_RUN2) ? duty2_q : duty_pwm;
   wire [15:0] per_use  = (state_d == S_RUN2) ? per2_q : per1_q;
   wire [31:0] prod     = 32'(duty_use) * 32'(per_use);
   wire [15:0] on_raw   = 16'(prod / 32'(dmax));
   // Pulses or pauses shorter than the minimum are suppressed.
   wire [15:0] off_raw  = per_use - on_raw;
   wire [15:0] on_calc  = (on_raw < minp_q) ? 16'h0000 :
                          (off_raw < minp_q) ? per_use : on_raw;

   wire train     = (cnt1_q != 23'h000000);
   wire per_end   = tick && (pos_q + 16'h0001 >= per_a_q);
   wire in_run    = (state_q == S_RUN1) || (state_q == S_RUN2);

   // Job decode and checks.
   always_comb begin
      resp_d = job_resp;
      if (req_rise) begin
         resp_d.done   = 1'b1;
         resp_d.err    = 1'b0;
         resp_d.stat   = pptj_pkg::ST_OK;
         case (code)
            pptj_pkg::JOB_NOP: ;
            pptj_pkg::JOB_WR_PER1, pptj_pkg::JOB_WR_PER2: begin
               if (neg || val < per_min) resp_d.stat = pptj_pkg::ST_PER_SMALL;
               else if (val > per_max)   resp_d.stat = pptj_pkg::ST_PER_BIG;
            end
            pptj_pkg::JOB_WR_DELAY: begin
               if (neg)                          resp_d.stat = pptj_pkg::ST_DLY_SMALL;
               else if (val > pptj_pkg::DLY_MAX) resp_d.stat = pptj_pkg::ST_DLY_BIG;
            end
            pptj_pkg::JOB_WR_MINP: begin
               if (neg || val < minp_lo) resp_d.stat = pptj_pkg::ST_MINP_SMALL;
               else if (val > half_p)    resp_d.stat = pptj_pkg::ST_MINP_BIG;
            end
            pptj_pkg::JOB_WR_CNT1, pptj_pkg::JOB_WR_CNT2: begin
               if (neg)                          resp_d.stat = pptj_pkg::ST_CNT_SMALL;
               else if (val > pptj_pkg::CNT_MAX) resp_d.stat = pptj_pkg::ST_CNT_BIG;
            end
            pptj_pkg::JOB_WR_TBASE: begin
               if (val > 32'h0000_0003) resp_d.stat = pptj_pkg::ST_TBASE_BAD;
            end
            pptj_pkg::JOB_ATTACH: begin
               if (state_q != S_RUN1 || !train || chain_q) resp_d.stat = pptj_pkg::ST_ATTACH_BAD;
            end
            pptj_pkg::JOB_RD_PER1:  resp_d.result = 32'(per1_q);
            pptj_pkg::JOB_RD_DELAY: resp_d.result = 32'(dly_q);
            pptj_pkg::JOB_RD_MINP:  resp_d.result = 32'(minp_q);
            pptj_pkg::JOB_RD_CNT1:  resp_d.result = 32'(cnt1_q);
            pptj_pkg::JOB_RD_CNT2:  resp_d.result = 32'(cnt2_q);
            pptj_pkg::JOB_RD_PER2:  resp_d.result = 32'(per2_q);
            pptj_pkg::JOB_RD_TBASE: resp_d.result = 32'(tbase_q);
            default:                resp_d.stat = pptj_pkg::ST_JOB_BAD;
         endcase
         resp_d.err = (resp_d.stat != pptj_pkg::ST_OK);
      end else if (job_req && !job_resp.done) begin
         resp_d.done = 1'b0;
      end
   end

   wire wr_ok = req_rise && !resp_d.err;

   // Sequencer for on-delay, PWM and chained pulse trains.
   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE:  if (gate_rise) state_d = S_DELAY;
         S_DELAY: if (dly_cnt_q == 16'h0000) state_d = S_RUN1;
         S_RUN1:  if (train && per_end && left_q == 23'h000001)
                     state_d = chain_q ? S_RUN2 : S_IDLE;
         S_RUN2:  if (per_end && left_q == 23'h000001) state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
      if (!software_gate) state_d = S_IDLE;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         req_q <= 1'b0;
         gate_q <= 1'b0;
         state_q <= S_IDLE;
         job_resp <= '{done: 1'b1, err: 1'b0, stat: pptj_pkg::ST_OK, result: 32'h0000_0000};
      end else begin
         req_q <= job_req;
         gate_q <= software_gate;
         state_q <= state_d;
         job_resp <= resp_d;
      end
   end

   // Setting store; a failed job leaves every setting unchanged.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         per1_q <= pptj_pkg::PER_RESET;
         per2_q <= pptj_pkg::PER_RESET;
         dly_q <= 16'h0000;
         minp_q <= pptj_pkg::MINP_RESET;
         cnt1_q <= 23'h000000;
         cnt2_q <= 23'h000000;
         tbase_q <= pptj_pkg::TBASE_RESET;
         duty2_q <= 16'h0000;
         chain_q <= 1'b0;
      end else begin
         if (wr_ok && code == pptj_pkg::JOB_WR_PER1)  per1_q <= val[15:0];
         if (wr_ok && code == pptj_pkg::JOB_WR_PER2)  per2_q <= val[15:0];
         if (wr_ok && code == pptj_pkg::JOB_WR_DELAY) dly_q <= val[15:0];
         if (wr_ok && code == pptj_pkg::JOB_WR_MINP)  minp_q <= val[15:0];
         if (wr_ok && code == pptj_pkg::JOB_WR_CNT1)  cnt1_q <= val[22:0];
         if (wr_ok && code == pptj_pkg::JOB_WR_CNT2)  cnt2_q <= val[22:0];
         if (wr_ok && code == pptj_pkg::JOB_WR_TBASE) tbase_q <= val[1:0];
         if (wr_ok && code == pptj_pkg::JOB_ATTACH) begin
            duty2_q <= (duty_value > dmax) ? dmax : duty_value;
            chain_q <= (cnt2_q != 23'h000000);
         end else if (state_q == S_IDLE && gate_rise) begin
            chain_q <= train && (cnt2_q != 23'h000000);
            duty2_q <= duty_pwm;
         end
      end
   end

   // Period timing; on time and period are latched at each period start.
   always_ff @(posedge sys_clk) begin
      if (!nrst || state_q == S_IDLE) begin
         // The delay is captured while idle, so a write during a running delay waits for the next gate rise.
         dly_cnt_q <= dly_q;
         pos_q <= 16'h0000;
         per_a_q <= 16'h0000;
         on_a_q <= 16'h0000;
         left_q <= 23'h000000;
      end else if (state_q == S_DELAY) begin
         if (tick) dly_cnt_q <= dly_cnt_q - 16'h0001;
         per_a_q <= per_use;
         on_a_q <= on_calc;
         left_q <= cnt1_q;
      end else if (per_end || state_q != state_d) begin
         pos_q <= 16'h0000;
         per_a_q <= (state_d == S_RUN2) ? per2_q : per_use;
         on_a_q <= on_calc;
         left_q <= (state_d == S_RUN2 && state_q == S_RUN1) ? cnt2_q : left_q - 23'h000001;
      end else if (tick) begin
         pos_q <= pos_q + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         output_active_status <= 1'b0;
         pulse_out <= 1'b0;
      end else begin
         output_active_status <= (state_d != S_IDLE);
         pulse_out <= in_run && (state_d == state_q) && (pos_q < on_a_q);
      end
   end
endmodule : pptj_unit
`default_nettype wire

/* File: pptj_unit_properties.sv */
`default_nettype none
module pptj_unit_properties (
   // Clock and reset.
   input wire logic                 sys_clk,
   input wire logic                 nrst,
   // Inputs.
   input wire logic                 format_analog,
   input wire logic                 software_gate,
   input wire logic [15:0]          duty_value,
   input wire logic                 job_req,
   input wire pptj_pkg::pptj_job_t  job_in,
   // Outputs.
   input wire pptj_pkg::pptj_resp_t job_resp,
   input wire logic                 output_active_status,
   input wire logic                 pulse_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   sequence s_req(logic [15:0] c);
      $rose(job_req) && job_in.code == c;
   endsequence
   sequence s_fail(logic [15:0] s);
      job_resp.err && job_resp.stat == s;
   endsequence
   property p_done;
      $rose(job_req) |=> job_resp.done;
   endproperty
   a_done: assert property (p_done) else $error("done low after request");
   property p_hold;
      !$rose(job_req) |=> $stable(job_resp);
   endproperty
   a_hold: assert property (p_hold) else $error("answer changed without request");
   property p_nop;
      s_req(pptj_pkg::JOB_NOP) |=> !job_resp.err && job_resp.stat == pptj_pkg::ST_OK;
   endproperty
   a_nop: assert property (p_nop) else $error("empty job failed");
   property p_bad;
      s_req(16'h00FF) |=> s_fail(pptj_pkg::ST_JOB_BAD);
   endproperty
   a_bad: assert property (p_bad) else $error("unknown job not refused");
   property p_per0;
      s_req(pptj_pkg::JOB_WR_PER1) ##0 job_in.value == 32'h0 |=> s_fail(pptj_pkg::ST_PER_SMALL);
   endproperty
   a_per0: assert property (p_per0) else $error("zero period not refused");
   property p_cnt;
      s_req(pptj_pkg::JOB_WR_CNT1) ##0 job_in.value == 32'h0080_0000 |=> s_fail(pptj_pkg::ST_CNT_BIG);
   endproperty
   a_cnt: assert property (p_cnt) else $error("count overflow not refused");
   property p_tb;
      s_req(pptj_pkg::JOB_WR_TBASE) ##0 job_in.value == 32'h4 |=> s_fail(pptj_pkg::ST_TBASE_BAD);
   endproperty
   a_tb: assert property (p_tb) else $error("bad time base not refused");
   property p_rise;
      $rose(software_gate) |=> output_active_status;
   endproperty
   a_rise: assert property (p_rise) else $error("gate rise did not start output");
   property p_stop;
      !software_gate |=> !output_active_status && !pulse_out;
   endproperty
   a_stop: assert property (p_stop) else $error("gate low did not stop output");
   property p_pulse;
      pulse_out |-> output_active_status;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse while inactive");
   property p_attach;
      s_req(pptj_pkg::JOB_ATTACH) ##0 !output_active_status |=> s_fail(pptj_pkg::ST_ATTACH_BAD);
   endproperty
   a_attach: assert property (p_attach) else $error("attach while idle not refused");
endmodule : pptj_unit_properties
bind pptj_unit pptj_unit_properties u_props (.sys_clk, .nrst, .format_analog, .software_gate, .duty_value,
   .job_req, .job_in, .job_resp, .output_active_status, .pulse_out);
`default_nettype wire

/* File: pptj_unit_tb.sv */
`default_nettype none
module pptj_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 sys_clk, nrst, format_analog, software_gate, job_req;
   logic [15:0]          duty_value;
   pptj_pkg::pptj_job_t  job_in;
   pptj_pkg::pptj_resp_t job_resp;
   logic                 output_active_status, pulse_out;
   logic [31:0]          hi_len, per_len, n_rise, n0;
   int                   fail_count, cmp_count;
   pptj_unit uut (.sys_clk(sys_clk), .nrst(nrst), .format_analog(format_analog), .software_gate(software_gate),
      .duty_value(duty_value), .job_req(job_req), .job_in(job_in), .job_resp(job_resp),
      .output_active_status(output_active_status), .pulse_out(pulse_out));
   pptj_line_model u_line (.sys_clk(sys_clk), .nrst(nrst), .line(pulse_out), .hi_len(hi_len),
      .per_len(per_len), .n_rise(n_rise));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk
   // The request is dropped with the parameters held, and two low cycles separate jobs.
   task automatic job(input logic [15:0] c, input logic [31:0] v, input logic [15:0] s);
      @(posedge sys_clk);
      #2;
      job_in.code  = c;
      job_in.value = v;
      job_req      = 1'b1;
      @(posedge sys_clk);
      #2;
      job_req = 1'b0;
      @(posedge sys_clk);
      #2;
      chk("done", {31'h0, job_resp.done}, 32'h1);
      chk("err", {31'h0, job_resp.err}, {31'h0, s != 16'h0});
      chk("stat", {16'h0, job_resp.stat}, {16'h0, s});
   endtask : job
   task automatic rd(input logic [15:0] c, input logic [31:0] exp);
      job(c, 32'h0, pptj_pkg::ST_OK);
      chk("result", job_resp.result, exp);
   endtask : rd
   task automatic wait_rises(input int n);
      n0 = n_rise;
      for (int i = 0; i < 20000 && n_rise < n0 + n; i++) @(posedge sys_clk);
      if (n_rise < n0 + n) begin
         fail_count++;
         $display("Error pulse wait expected %0d seen %0d", n, n_rise - n0);
         print_verdict();
      end
      #2;
   endtask : wait_rises
   initial begin
      nrst          = 1'b0;
      format_analog = 1'b0;
      software_gate = 1'b0;
      duty_value    = 16'h0000;
      job_req       = 1'b0;
      job_in        = '0;
      repeat (3) @(posedge sys_clk);
      #2;
      nrst = 1'b1;
      chk("done_rst", {31'h0, job_resp.done}, 32'h1);
      rd(pptj_pkg::JOB_RD_PER1, 32'h0000_4E20);
      rd(pptj_pkg::JOB_RD_MINP, 32'h0000_0002);
      rd(pptj_pkg::JOB_RD_TBASE, 32'h0000_0000);
      job(pptj_pkg::JOB_NOP, 32'h0000_1234, pptj_pkg::ST_OK);
      rd(pptj_pkg::JOB_RD_PER1, 32'h0000_4E20);
      job(16'h00FF, 32'h0000_0000, pptj_pkg::ST_JOB_BAD);
      job(pptj_pkg::JOB_WR_TBASE, 32'h0000_0004, pptj_pkg::ST_TBASE_BAD);
      job(pptj_pkg::JOB_WR_TBASE, 32'h0000_0002, pptj_pkg::ST_OK);
      rd(pptj_pkg::JOB_RD_TBASE, 32'h0000_0002);
      job(pptj_pkg::JOB_WR_PER1, 32'h0000_0000, pptj_pkg::ST_PER_SMALL);
      job(pptj_pkg::JOB_WR_PER1, 32'h0000_0013, pptj_pkg::ST_PER_SMALL);
      job(pptj_pkg::JOB_WR_PER1, 32'h0001_0000, pptj_pkg::ST_PER_BIG);
      job(pptj_pkg::JOB_WR_PER1, 32'h0000_0014, pptj_pkg::ST_OK);
      rd(pptj_pkg::JOB_RD_PER1, 32'h0000_0014);
      job(pptj_pkg::JOB_WR_DELAY, 32'h0001_0000, pptj_pkg::ST_DLY_BIG);
      job(pptj_pkg::JOB_WR_DELAY, 32'h0000_0000, pptj_pkg::ST_OK);
      rd(pptj_pkg::JOB_RD_DELAY, 32'h0000_0000);
      job(pptj_pkg::JOB_WR_MINP, 32'h0000_0004, pptj_pkg::ST_MINP_SMALL);
      job(pptj_pkg::JOB_WR_MINP, 32'h0000_000B, pptj_pkg::ST_MINP_BIG);
      job(pptj_pkg::JOB_WR_MINP, 32'h0000_0005, pptj_pkg::ST_OK);
      rd(pptj_pkg::JOB_RD_MINP, 32'h0000_0005);
      job(pptj_pkg::JOB_WR_CNT1, 32'h0080_0000, pptj_pkg::ST_CNT_BIG);
      job(pptj_pkg::JOB_WR_CNT2, 32'h007F_FFFF, pptj_pkg::ST_OK);
      rd(pptj_pkg::JOB_RD_CNT2, 32'h007F_FFFF);
      job(pptj_pkg::JOB_WR_CNT2, 32'h0000_0000, pptj_pkg::ST_OK);
      job(pptj_pkg::JOB_WR_PER2, 32'h0000_001E, pptj_pkg::ST_OK);
      rd(pptj_pkg::JOB_RD_PER2, 32'h0000_001E);
      rd(pptj_pkg::JOB_RD_PER1, 32'h0000_0014);
      job(pptj_pkg::JOB_ATTACH, 32'h0000_0000, pptj_pkg::ST_ATTACH_BAD);
      // At 1us ticks of 20 clocks a 20 tick period is 400 clocks.
      duty_value    = 16'h01F4;
      software_gate = 1'b1;
      @(posedge sys_clk);
      #2;
      chk("active", {31'h0, output_active_status}, 32'h1);
      wait_rises(3);
      chk("hi", hi_len, 32'h0000_00C8);
      chk("per", per_len, 32'h0000_0190);
      format_analog = 1'b1;
      duty_value    = 16'h1B00;
      wait_rises(3);
      chk("hi_analog", hi_len, 32'h0000_0064);
      job(pptj_pkg::JOB_WR_PER1, 32'h0000_0028, pptj_pkg::ST_OK);
      job(pptj_pkg::JOB_WR_PER2, 32'h0000_0032, pptj_pkg::ST_OK);
      wait_rises(3);
      chk("per_new", per_len, 32'h0000_0320);
      chk("hi_new", hi_len, 32'h0000_00C8);
      chk("active_run", {31'h0, output_active_status}, 32'h1);
      software_gate = 1'b0;
      @(posedge sys_clk);
      #2;
      chk("stop", {30'h0, output_active_status, pulse_out}, 32'h0);
      format_analog = 1'b0;
      duty_value    = 16'h01F4;
      job(pptj_pkg::JOB_WR_PER1, 32'h0000_0014, pptj_pkg::ST_OK);
      job(pptj_pkg::JOB_WR_CNT1, 32'h0000_0003, pptj_pkg::ST_OK);
      rd(pptj_pkg::JOB_RD_CNT1, 32'h0000_0003);
      n0            = n_rise;
      software_gate = 1'b1;
      @(posedge sys_clk);
      #2;
      // Second job of 2 pulses at 50 ticks is attached while the first runs, at a quarter duty.
      duty_value = 16'h00FA;
      job(pptj_pkg::JOB_WR_CNT2, 32'h0000_0002, pptj_pkg::ST_OK);
      job(pptj_pkg::JOB_ATTACH, 32'h0000_0000, pptj_pkg::ST_OK);
      job(pptj_pkg::JOB_ATTACH, 32'h0000_0000, pptj_pkg::ST_ATTACH_BAD);
      for (int i = 0; i < 20000 && output_active_status === 1'b1; i++) @(posedge sys_clk);
      #2;
      chk("pulses", n_rise - n0, 32'h0000_0005);
      chk("hi_second", hi_len, 32'h0000_00F0);
      chk("per_second", per_len, 32'h0000_03E8);
      chk("train_end", {31'h0, output_active_status}, 32'h0);
      software_gate = 1'b0;
      job(pptj_pkg::JOB_WR_CNT1, 32'h0000_0000, pptj_pkg::ST_OK);
      print_verdict();
   end
endmodule : pptj_unit_tb
`default_nettype wire
